/* crt_map.vh */
/* Register offsets, fields, reset values and counts.
   Assumes inclusion by bare name. */
`ifndef CRT_MAP_VH
`define CRT_MAP_VH

`define CRT_ADDR_CTRL       8'h00
`define CRT_ADDR_BTR1       8'h04
`define CRT_ADDR_BTR3       8'h08
`define CRT_ADDR_OBJ_EN     8'h0c
`define CRT_ADDR_OBJ_STAT   8'h10
`define CRT_ADDR_IRQ_STAT   8'h14
`define CRT_ADDR_IRQ_MASK   8'h18
`define CRT_ADDR_STATE      8'h1c
`define CRT_REGION_ID       2'b01
`define CRT_REGION_MASK     2'b10

`define CRT_CTRL_TXREQ      0
`define CRT_BTR3_TRIPLE     0
`define CRT_ID_IDE          29
`define CRT_IRQ_RXDONE      0
`define CRT_IRQ_ACKERR      1
`define CRT_IRQ_ARBLOST     2
`define CRT_IRQ_TXOK        3
`define CRT_STATE_NEED_LSB  4
`define CRT_STATE_COUNTING  8
`define CRT_STATE_TXREQ     9
`define CRT_STATE_HAZARD    10
`define CRT_STATE_LOST      11

`define CRT_RST_BRP         6'h00
`define CRT_RST_TRIPLE      1'b0
`define CRT_RST_IRQ_MASK    4'h0
`define CRT_RST_ID          30'h00000000
`define CRT_RST_MASK        30'h3fffffff

`define CRT_IMS_STD         3'h3
`define CRT_IMS_NOACC       3'h4
`define CRT_IMS_MAX         3'h7
`define CRT_TQ_PER_BIT      5'h0a
`define CRT_SAMPLE_TQ       5'h07
`define CRT_N_OBJ           15

`define CRT_RESP_OKAY       2'b00
`define CRT_RESP_SLVERR     2'b10

`endif

/* crt_bit_timer.v */
/* Bit timer: prescaler and bit-cell counter with three sample pulses.
   Assumes hard_sync is a same-clock pulse at start of frame. */
`timescale 1ns/10ps
`default_nettype none
`include "crt_map.vh"

module crt_bit_timer #(
    parameter [4:0] TQ_PER_BIT = `CRT_TQ_PER_BIT,
    parameter [4:0] SAMPLE_TQ  = `CRT_SAMPLE_TQ
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [5:0] bit_rate_prescaler,
    input  wire       hard_sync,
    output reg        samp_a_q,
    output reg        samp_b_q,
    output reg        samp_c_q
);
    localparam [4:0] TQ_LAST = TQ_PER_BIT - 5'h01;

    reg  [5:0] pre_q;
    reg  [4:0] tq_q;
    wire       tq_tick;

    assign tq_tick = (pre_q == bit_rate_prescaler);

    always @(posedge aclk) begin
        if (!aresetn || hard_sync) begin
            pre_q    <= 6'h00;
            tq_q     <= 5'h00;
            samp_a_q <= 1'b0;
            samp_b_q <= 1'b0;
            samp_c_q <= 1'b0;
        end else begin
            pre_q    <= tq_tick ? 6'h00 : pre_q + 6'h01;
            if (tq_tick) begin
                tq_q <= (tq_q == TQ_LAST) ? 5'h00 : tq_q + 5'h01;
            end
            samp_a_q <= tq_tick && (tq_q == SAMPLE_TQ - 5'h02);
            samp_b_q <= tq_tick && (tq_q == SAMPLE_TQ - 5'h01);
            samp_c_q <= tq_tick && (tq_q == SAMPLE_TQ);
        end
    end
endmodule
`default_nettype wire

/* crt_sampler.v */
/* Sampler: two-flop synchroniser, then single or majority sampling.
   Assumes sample pulses from the bit timer on the same clock. */
`timescale 1ns/10ps
`default_nettype none

module crt_sampler (
    input  wire aclk,
    input  wire aresetn,
    input  wire can_rx,
    input  wire triple,
    input  wire samp_a,
    input  wire samp_b,
    input  wire samp_c,
    output reg  bit_q,
    output reg  bit_valid_q
);
    reg  meta_q;
    reg  sync_q;
    reg  s_a_q;
    reg  s_b_q;
    wire maj;

    assign maj = (s_a_q & s_b_q) | (s_a_q & sync_q) | (s_b_q & sync_q);

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q      <= 1'b1;
            sync_q      <= 1'b1;
            s_a_q       <= 1'b1;
            s_b_q       <= 1'b1;
            bit_q       <= 1'b1;
            bit_valid_q <= 1'b0;
        end else begin
            meta_q      <= can_rx;
            sync_q      <= meta_q;
            bit_valid_q <= samp_c;
            if (samp_a) begin
                s_a_q <= sync_q;
            end
            if (samp_b) begin
                s_b_q <= sync_q;
            end
            if (samp_c) begin
                bit_q <= triple ? maj : sync_q;
            end
        end
    end
endmodule
`default_nettype wire

/* crt_top.v */
/* CAN retry and receive timing: intermission before transmit, receive
   objects, AXI4-Lite registers and interrupt.
   Assumes a same-clock engine giving one-cycle field pulses. */
`timescale 1ns/10ps
`default_nettype none
`include "crt_map.vh"

// What this block does and what its software must do
// RL1 - Zero prescaler with triple sampling may give spurious ack errors.
// RL2 - Software uses single sampling with zero prescaler.
// RL3 - Transmit request on busy bus waits three-bit intermission.
// RL4 - Lost arbitration with own acceptance retries after three bits.
// RL5 - Lost arbitration without acceptance retries after four bits.
// RL6 - Objects enabled by the first length bit take part.
// RL7 - Status and done flag update after sixth end bit.
// RL8 - Software has 19 or 39 bit times to re-enable.
// RL9 - Matching non-last objects take frames; last takes leftovers.
// RL10 - Software keeps a receive object always enabled.
// RL11 - Only the lowest hit index is updated.
// RL12 - Software clears done flags by read-modify-write.
// RL13 - Intermission counts recessive bit times after frame end.
module crt_top #(
    parameter       N_OBJ      = `CRT_N_OBJ,
    parameter [4:0] TQ_PER_BIT = `CRT_TQ_PER_BIT,
    parameter [4:0] SAMPLE_TQ  = `CRT_SAMPLE_TQ
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        can_rx,
    input  wire        pe_sof,
    input  wire        pe_dlc_first,
    input  wire [28:0] pe_id,
    input  wire        pe_ide,
    input  wire        pe_eof6,
    input  wire        pe_eof_end,
    input  wire        pe_frame_ok,
    input  wire        pe_arb_lost,
    input  wire        pe_ack_slot,
    input  wire        pe_tx_ok,
    output wire        rx_bit,
    output reg         tx_start,
    output reg         irq
);
    reg  [5:0]       bit_rate_prescaler_q;
    reg              triple_sample_select_q, tx_req_q, counting_q, lost_q, ack_pend_q;
    reg  [N_OBJ-1:0] obj_en_q, obj_stat_q, hit_q;
    reg  [3:0]       irq_stat_q, irq_mask_q, w_strb_q;
    reg  [29:0]      id_q   [0:N_OBJ-1];
    reg  [29:0]      mask_q [0:N_OBJ-1];
    reg  [2:0]       ims_q, need_q;
    reg              aw_have_q, w_have_q;
    reg  [7:0]       aw_addr_q;
    reg  [31:0]      w_data_q;
    wire             samp_a, samp_b, samp_c, bit_valid, cfg_hazard, do_wr;
    wire [N_OBJ-1:0] match, winner;
    wire [31:0]      wmask, wset, wclr0;
    wire [3:0]       wr_idx, irq_ev;
    wire             wr_id_hit, wr_mask_hit, rx_store, ack_err, tx_go;
    reg              wr_map, rd_map;
    reg  [31:0]      rd_val;
    crt_bit_timer #(
        .TQ_PER_BIT (TQ_PER_BIT),
        .SAMPLE_TQ  (SAMPLE_TQ)
    ) u_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .bit_rate_prescaler       (bit_rate_prescaler_q),
        .hard_sync (pe_sof),
        .samp_a_q  (samp_a),
        .samp_b_q  (samp_b),
        .samp_c_q  (samp_c)
    );

    crt_sampler u_sampler (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .can_rx      (can_rx),
        .triple      (triple_sample_select_q),
        .samp_a      (samp_a),
        .samp_b      (samp_b),
        .samp_c      (samp_c),
        .bit_q       (rx_bit),
        .bit_valid_q (bit_valid)
    );

    // Quanta of one clock leave no room for a real majority window
    assign cfg_hazard = (bit_rate_prescaler_q == 6'h00) && triple_sample_select_q; // RL1

    // Filter: masked identifier bits and the masked extended flag must agree
    genvar g;
    generate
        for (g = 0; g < N_OBJ; g = g + 1) begin : g_obj
            assign match[g] = (((({pe_ide, pe_id} ^ id_q[g]) & mask_q[g]) == 30'h0)); // RL9
            always @(posedge aclk) begin
                if (!aresetn) begin
                    id_q[g]   <= `CRT_RST_ID;
                    mask_q[g] <= `CRT_RST_MASK;
                end else if (do_wr && wr_idx == g) begin
                    if (wr_id_hit) begin
                        id_q[g]   <= (id_q[g] & ~wmask[29:0]) | (w_data_q[29:0] & wmask[29:0]);
                    end
                    if (wr_mask_hit) begin
                        mask_q[g] <= (mask_q[g] & ~wmask[29:0]) | (w_data_q[29:0] & wmask[29:0]);
                    end
                end
            end
        end
    endgenerate

    function [N_OBJ-1:0] pick;
        input [N_OBJ-1:0] h;
        integer           k;
        reg               found;
        begin
            pick  = {N_OBJ{1'b0}};
            found = 1'b0;
            for (k = 0; k < N_OBJ - 1; k = k + 1) begin
                if (h[k] && !found) begin
                    pick[k] = 1'b1; // RL11
                    found   = 1'b1;
                end
            end
            // Last object is the catch-all of lowest priority
            if (!found && h[N_OBJ-1]) begin
                pick[N_OBJ-1] = 1'b1; // RL9
            end
        end
    endfunction

    assign winner   = pick(hit_q);
    assign rx_store = pe_eof6 && pe_frame_ok; // RL7
    assign ack_err  = ack_pend_q && bit_valid && rx_bit;
    assign tx_go    = tx_req_q && counting_q && (ims_q >= need_q) && !tx_start; // RL3
    assign irq_ev   = {pe_tx_ok, pe_arb_lost, ack_err, rx_store && (|hit_q)};

    // Register write side
    assign do_wr       = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wmask       = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wset        = w_data_q & wmask;
    assign wclr0       = ~w_data_q & wmask;
    assign wr_idx      = aw_addr_q[5:2];
    assign wr_id_hit   = (aw_addr_q[7:6] == `CRT_REGION_ID) && (wr_idx < N_OBJ);
    assign wr_mask_hit = (aw_addr_q[7:6] == `CRT_REGION_MASK) && (wr_idx < N_OBJ);

    always @* begin
        case (aw_addr_q)
            `CRT_ADDR_CTRL, `CRT_ADDR_BTR1, `CRT_ADDR_BTR3, `CRT_ADDR_OBJ_EN,
            `CRT_ADDR_OBJ_STAT, `CRT_ADDR_IRQ_STAT, `CRT_ADDR_IRQ_MASK,
            `CRT_ADDR_STATE: wr_map = 1'b1;
            default:         wr_map = wr_id_hit || wr_mask_hit;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CRT_RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_have_q     <= 1'b0;
                w_have_q      <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_map ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Configuration, objects and flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            bit_rate_prescaler_q   <= `CRT_RST_BRP;
            triple_sample_select_q <= `CRT_RST_TRIPLE;
            tx_req_q               <= 1'b0;
            obj_en_q               <= {N_OBJ{1'b0}};
            obj_stat_q             <= {N_OBJ{1'b0}};
            irq_stat_q             <= 4'h0;
            irq_mask_q             <= `CRT_RST_IRQ_MASK;
            irq                    <= 1'b0;
        end else begin
            if (do_wr && aw_addr_q == `CRT_ADDR_BTR1) begin
                bit_rate_prescaler_q <= (bit_rate_prescaler_q & ~wmask[5:0]) | wset[5:0];
            end
            if (do_wr && aw_addr_q == `CRT_ADDR_BTR3 && wmask[`CRT_BTR3_TRIPLE]) begin
                triple_sample_select_q <= w_data_q[`CRT_BTR3_TRIPLE];
            end
            if (do_wr && aw_addr_q == `CRT_ADDR_IRQ_MASK) begin
                irq_mask_q <= (irq_mask_q & ~wmask[3:0]) | wset[3:0];
            end
            // Request holds through lost arbitration until sent
            if (pe_tx_ok) begin
                tx_req_q <= 1'b0;
            end else if (do_wr && aw_addr_q == `CRT_ADDR_CTRL && wmask[`CRT_CTRL_TXREQ]) begin
                tx_req_q <= w_data_q[`CRT_CTRL_TXREQ];
            end
            // Object is one-shot; a re-enable write in the same cycle wins
            if (do_wr && aw_addr_q == `CRT_ADDR_OBJ_EN) begin
                obj_en_q <= (obj_en_q & ~wmask[N_OBJ-1:0]) | wset[N_OBJ-1:0];
            end else if (rx_store) begin
                obj_en_q <= obj_en_q & ~winner;
            end
            // Writing zero clears a done bit; a new set wins
            obj_stat_q <= (obj_stat_q & ((do_wr && aw_addr_q == `CRT_ADDR_OBJ_STAT) ?
                          ~wclr0[N_OBJ-1:0] : {N_OBJ{1'b1}})) |
                          (rx_store ? winner : {N_OBJ{1'b0}}); // RL7
            irq_stat_q <= (irq_stat_q & ((do_wr && aw_addr_q == `CRT_ADDR_IRQ_STAT) ?
                          ~wset[3:0] : 4'hf)) | irq_ev;
            irq        <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Frame tracking, acceptance and intermission
    always @(posedge aclk) begin
        if (!aresetn) begin
            hit_q      <= {N_OBJ{1'b0}};
            ims_q      <= 3'h0;
            need_q     <= `CRT_IMS_STD;
            counting_q <= 1'b1;
            lost_q     <= 1'b0;
            ack_pend_q <= 1'b0;
            tx_start   <= 1'b0;
        end else begin
            tx_start <= tx_go;
            if (pe_dlc_first) begin
                hit_q <= obj_en_q & match; // RL6
            end
            if (pe_arb_lost) begin
                lost_q <= 1'b1;
            end
            if (pe_ack_slot) begin
                ack_pend_q <= 1'b1;
            end else if (bit_valid) begin
                ack_pend_q <= 1'b0;
            end
            if (pe_eof_end) begin
                counting_q <= 1'b1;
                ims_q      <= 3'h0;
                lost_q     <= 1'b0;
                hit_q      <= {N_OBJ{1'b0}};
                // A lost frame nobody here accepted costs one extra bit
                need_q     <= (lost_q && !(|hit_q)) ? `CRT_IMS_NOACC : `CRT_IMS_STD; // RL4 RL5
            end else if (pe_sof || tx_go) begin
                counting_q <= 1'b0;
            end else if (counting_q && bit_valid) begin
                if (!rx_bit) begin
                    ims_q <= 3'h0; // RL13
                end else if (ims_q != `CRT_IMS_MAX) begin
                    ims_q <= ims_q + 3'h1; // RL13
                end
            end
        end
    end

    // Read side
    always @* begin
        rd_val = 32'h00000000;
        rd_map = 1'b1;
        case (s_axi_araddr)
            `CRT_ADDR_CTRL:     rd_val[`CRT_CTRL_TXREQ] = tx_req_q;
            `CRT_ADDR_BTR1:     rd_val[5:0] = bit_rate_prescaler_q;
            `CRT_ADDR_BTR3:     rd_val[`CRT_BTR3_TRIPLE] = triple_sample_select_q;
            `CRT_ADDR_OBJ_EN:   rd_val[N_OBJ-1:0] = obj_en_q;
            `CRT_ADDR_OBJ_STAT: rd_val[N_OBJ-1:0] = obj_stat_q;
            `CRT_ADDR_IRQ_STAT: rd_val[3:0] = irq_stat_q;
            `CRT_ADDR_IRQ_MASK: rd_val[3:0] = irq_mask_q;
            `CRT_ADDR_STATE: begin
                rd_val[2:0]                  = ims_q;
                rd_val[`CRT_STATE_NEED_LSB+2:`CRT_STATE_NEED_LSB] = need_q;
                rd_val[`CRT_STATE_COUNTING]  = counting_q;
                rd_val[`CRT_STATE_TXREQ]     = tx_req_q;
                rd_val[`CRT_STATE_HAZARD]    = cfg_hazard;
                rd_val[`CRT_STATE_LOST]      = lost_q;
            end
            default: begin
                if (s_axi_araddr[7:6] == `CRT_REGION_ID && s_axi_araddr[5:2] < N_OBJ) begin
                    rd_val[29:0] = id_q[s_axi_araddr[5:2]];
                end else if (s_axi_araddr[7:6] == `CRT_REGION_MASK &&
                             s_axi_araddr[5:2] < N_OBJ) begin
                    rd_val[29:0] = mask_q[s_axi_araddr[5:2]];
                end else begin
                    rd_map = 1'b0;
                end
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CRT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_map ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* crt_top_sva.sv */
/* Checker on crt_top ports: bus handshakes and transmit start timing.
   Assumes one clock domain and is bound to every crt_top instance. */
`timescale 1ns/10ps
`default_nettype none
module crt_top_sva #(
    parameter [4:0] TQ_PER_BIT = 5'h0a
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        pe_sof,
    input wire logic        pe_eof_end,
    input wire logic        tx_start
);
    logic [7:0] gap_q;
    // Reset also starts a fresh intermission, so zero is right there too
    always @(posedge aclk) begin
        if (!aresetn || pe_eof_end) gap_q <= 8'h00;
        else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    tx_one_cycle_a: assert property (tx_start |=> !tx_start)
        else $error("tx_start held longer than one cycle");
    sof_blocks_tx_a: assert property (pe_sof |-> ##2 !tx_start [*8])
        else $error("tx_start while a frame is on the bus");
    eof_gap_a: assert property (tx_start |-> gap_q >= 2 * TQ_PER_BIT)
        else $error("tx_start before intermission elapsed");
    aw_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after handshake");
    w_taken_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("wready stayed high after handshake");
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
endmodule
bind crt_top crt_top_sva #(.TQ_PER_BIT(TQ_PER_BIT)) u_sva (.*);
`default_nettype wire

/* crt_can_node.sv */
/* Far side: bus traffic from other nodes as pin level and frame events.
   Assumes the caller enters frame just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module crt_can_node (
    input  wire logic        aclk,
    output var  logic        can_rx,
    output var  logic        pe_sof,
    output var  logic        pe_dlc_first,
    output var  logic [28:0] pe_id,
    output var  logic        pe_ide,
    output var  logic        pe_eof6,
    output var  logic        pe_eof_end,
    output var  logic        pe_frame_ok,
    output var  logic        pe_arb_lost,
    output var  logic        pe_ack_slot,
    output var  logic        pe_tx_ok
);
    initial begin
        can_rx = 1'b1;
        pe_id = 29'h0;
        {pe_sof, pe_dlc_first, pe_ide, pe_eof6, pe_eof_end} = 5'h00;
        {pe_frame_ok, pe_arb_lost, pe_ack_slot, pe_tx_ok} = 4'h0;
    end
    // Fixed cycle counts keep every frame at the same bit phase
    task frame(input [28:0] id, input lost, input own, input ack_rec);
        begin
            pe_sof <= 1'b1;
            can_rx <= 1'b0;
            @(posedge aclk);
            pe_sof <= 1'b0;
            repeat (30) @(posedge aclk);
            pe_arb_lost <= lost;
            @(posedge aclk);
            pe_arb_lost <= 1'b0;
            pe_id <= id;
            pe_dlc_first <= 1'b1;
            @(posedge aclk);
            pe_dlc_first <= 1'b0;
            pe_id <= ~id;
            repeat (40) @(posedge aclk);
            pe_ack_slot <= own;
            can_rx <= ack_rec;
            @(posedge aclk);
            pe_ack_slot <= 1'b0;
            repeat (20) @(posedge aclk);
            can_rx <= 1'b1;
            repeat (40) @(posedge aclk);
            pe_eof6 <= 1'b1;
            pe_frame_ok <= 1'b1;
            pe_tx_ok <= own & ~lost;
            @(posedge aclk);
            {pe_eof6, pe_frame_ok, pe_tx_ok} <= 3'h0;
            repeat (10) @(posedge aclk);
            pe_eof_end <= 1'b1;
            @(posedge aclk);
            pe_eof_end <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* crt_top_test.sv */
/* Self-checking bench for crt_top with a bus node model and AXI master.
   Assumes crt_map.vh is on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "crt_map.vh"
module crt_top_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, g3, last_gap, gap = 8'h00;
    logic [31:0] s_axi_wdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  r, s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        can_rx, pe_sof, pe_dlc_first, pe_ide, pe_eof6, pe_eof_end, pe_frame_ok;
    logic        pe_arb_lost, pe_ack_slot, pe_tx_ok, rx_bit, tx_start, irq;
    logic [28:0] pe_id;
    int          mismatches = 0, check_count = 0, tx_n = 0, n0;
    crt_top u_dut (.*);
    crt_can_node u_node (.*);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        gap <= pe_eof_end ? 8'h00 : gap + 8'h01;
        if (tx_start) begin
            last_gap <= gap;
            tx_n <= tx_n + 1;
        end
    end
    task summarize;
        begin
            if (mismatches == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input string m);
        begin
            check_count++;
            if (got !== exp) begin
                mismatches++;
                $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            @(posedge aclk);
            while (!(s_axi_bvalid && s_axi_bready)) begin
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) s_axi_bready <= 1'b1;
                @(posedge aclk);
            end
            s_axi_bready <= 1'b0;
        end
    endtask
    // Late rready on purpose, so read data must be held
    task rd(input [7:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            @(posedge aclk);
            while (!(s_axi_rvalid && s_axi_rready)) begin
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) s_axi_rready <= 1'b1;
                @(posedge aclk);
            end
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task wt;
        int i;
        begin
            i = 0;
            while (!tx_start && i < 200) begin
                @(posedge aclk);
                i++;
            end
            @(posedge aclk);
            chk(i < 200, 1, "tx_start missing");
        end
    endtask
    task t_regs;
        begin
            rd(`CRT_ADDR_BTR1); chk(d, 0, "prescaler reset");
            rd(`CRT_ADDR_IRQ_MASK); chk(d, 0, "mask reset");
            rd(8'h80); chk(d, 32'h3fffffff, "filter mask reset");
            rd(`CRT_ADDR_STATE); chk(d[8:4], 5'h13, "state reset");
            rd(8'h3c); chk(d, 0, "unmapped data"); chk(r, `CRT_RESP_SLVERR, "unmapped resp");
            wr(`CRT_ADDR_BTR3, 32'h1);
            rd(`CRT_ADDR_STATE); chk(d[10], 1, "hazard flag");
            wr(`CRT_ADDR_BTR3, 32'h0);
            rd(`CRT_ADDR_STATE); chk(d[10], 0, "hazard flag clear");
        end
    endtask
    task t_tx;
        begin
            wr(`CRT_ADDR_OBJ_EN, 32'h1);
            n0 = tx_n;
            fork
                u_node.frame(29'h0, 1'b0, 1'b0, 1'b0);
                begin
                    repeat (5) @(posedge aclk);
                    wr(`CRT_ADDR_CTRL, 32'h1);
                end
            join
            chk(tx_n, n0, "start on busy bus");
            wt;
            chk(last_gap > 8'h14 && last_gap <= 8'h22, 1, "intermission");
            wr(`CRT_ADDR_OBJ_EN, 32'h1);
            u_node.frame(29'h0, 1'b1, 1'b0, 1'b0);
            rd(`CRT_ADDR_STATE); chk(d[6:4], 3'h3, "retry with hit");
            wt;
            g3 = last_gap;
            u_node.frame(29'h0, 1'b1, 1'b0, 1'b0);
            rd(`CRT_ADDR_STATE); chk(d[6:4], 3'h4, "retry no hit");
            wt;
            chk(last_gap - g3, `CRT_TQ_PER_BIT, "extra bit");
            u_node.frame(29'h0, 1'b0, 1'b1, 1'b0);
            rd(`CRT_ADDR_STATE); chk(d[9], 0, "request cleared");
        end
    endtask
    task t_rx;
        begin
            wr(`CRT_ADDR_OBJ_STAT, 32'h0);
            wr(`CRT_ADDR_IRQ_STAT, 32'hf);
            wr(8'hb8, 32'h0);
            wr(`CRT_ADDR_OBJ_EN, 32'h4003);
            u_node.frame(29'h0, 1'b0, 1'b0, 1'b0);
            rd(`CRT_ADDR_OBJ_STAT); chk(d, 32'h1, "lowest hit wins");
            rd(`CRT_ADDR_OBJ_EN); chk(d, 32'h4002, "winner disabled");
            u_node.frame(29'h5, 1'b0, 1'b0, 1'b0);
            rd(`CRT_ADDR_OBJ_STAT); chk(d, 32'h4001, "last object catch");
            rd(`CRT_ADDR_IRQ_STAT); chk(d[0], 1, "receive done");
            chk(irq, 0, "masked irq");
            wr(`CRT_ADDR_IRQ_MASK, 32'h1);
            repeat (2) @(posedge aclk);
            chk(irq, 1, "irq raised");
            wr(`CRT_ADDR_IRQ_STAT, 32'h1);
            repeat (2) @(posedge aclk);
            chk(irq, 0, "irq cleared");
            rd(`CRT_ADDR_OBJ_STAT);
            wr(`CRT_ADDR_OBJ_STAT, d & 32'hfffffffe);
            rd(`CRT_ADDR_OBJ_STAT); chk(d, 32'h4000, "status rmw");
            u_node.frame(29'h0, 1'b0, 1'b1, 1'b1);
            rd(`CRT_ADDR_IRQ_STAT); chk(d[1], 1, "ack error");
        end
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_tx;
        t_rx;
        summarize;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        summarize;
    end
endmodule
`default_nettype wire
